/* core/ptsr_pkg.sv */
// Package with offsets, field positions, reset values and timing counts of the register slice.
package ptsr_pkg;

	// Register offsets.
	localparam logic [7:0] ADDR_LIMIT_HIGH_LO  = 8'h46;
	localparam logic [7:0] ADDR_LIMIT_HIGH_HI  = 8'h47;
	localparam logic [7:0] ADDR_LIMIT_LOW_LO   = 8'h48;
	localparam logic [7:0] ADDR_LIMIT_LOW_HI   = 8'h49;
	localparam logic [7:0] ADDR_OFFSET_LO      = 8'h4C;
	localparam logic [7:0] ADDR_OFFSET_HI      = 8'h4D;
	localparam logic [7:0] ADDR_SIGNAL_STATUS  = 8'h60;
	localparam logic [7:0] ADDR_STATUS_MIRROR  = 8'h61;

	// Reset values.
	localparam logic [7:0]  RESET_BYTE          = 8'h00;
	localparam logic [15:0] RESET_WORD          = 16'h0000;

	// Signal-path status field positions.
	localparam int BIT_SELFTEST_NOT_RUN  = 3;
	localparam int BIT_SELFTEST_RUNNING  = 2;
	localparam int BIT_COMMON_MODE_FAULT = 1;
	localparam int BIT_SELFTEST_FAULT    = 0;

	// Device status reserved bit.
	localparam int BIT_STATUS_RESERVED   = 6;

	// Stretch select encodings.
	localparam logic [1:0] STRETCH_NONE  = 2'b00;
	localparam logic [1:0] STRETCH_SHORT = 2'b01;
	localparam logic [1:0] STRETCH_MID   = 2'b10;
	localparam logic [1:0] STRETCH_LONG  = 2'b11;

	// Clock and stretch times.
	localparam int CLOCK_HZ          = 25_000_000;
	localparam int STRETCH_SHORT_US  = 16_000;
	localparam int STRETCH_MID_US    = 64_000;
	localparam int STRETCH_LONG_US   = 256_000;
	localparam int STRETCH_SHORT_CYC = STRETCH_SHORT_US * (CLOCK_HZ / 1_000_000);
	localparam int STRETCH_MID_CYC   = STRETCH_MID_US * (CLOCK_HZ / 1_000_000);
	localparam int STRETCH_LONG_CYC  = STRETCH_LONG_US * (CLOCK_HZ / 1_000_000);
	localparam int STRETCH_WIDTH     = 23;

endpackage : ptsr_pkg

/* core/ptsr_lock_reg.sv */
// Lockable byte register with change detection.
`timescale 1ns/10ps

module ptsr_lock_reg (
	input  wire logic       CLK_IN,
	input  wire logic       RESET_IN,
	input  wire logic       ENABLE_IN,
	input  wire logic       WRITE_IN,
	input  wire logic       LOCK_IN,
	input  wire logic [7:0] DATA_IN,
	output logic      [7:0] VALUE_OUT,
	output logic            CHANGE_OUT
);
	import ptsr_pkg::*;

	// A write is taken only while the init lock is open.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			VALUE_OUT <= RESET_BYTE;
		end else if (ENABLE_IN && WRITE_IN && !LOCK_IN) begin
			VALUE_OUT <= DATA_IN; // R01
		end
	end

	// Flags an accepted write whose data differs from the held value.
	assign CHANGE_OUT = ENABLE_IN && WRITE_IN && !LOCK_IN && (DATA_IN != VALUE_OUT);

endmodule // ptsr_lock_reg

/* core/ptsr_stretch.sv */
// Interrupt pulse-stretch counter.
`timescale 1ns/10ps

module ptsr_stretch #(
	parameter int SHORT_CYC = ptsr_pkg::STRETCH_SHORT_CYC,
	parameter int MID_CYC   = ptsr_pkg::STRETCH_MID_CYC,
	parameter int LONG_CYC  = ptsr_pkg::STRETCH_LONG_CYC
) (
	input  wire logic       CLK_IN,
	input  wire logic       RESET_IN,
	input  wire logic       ENABLE_IN,
	input  wire logic       SAMPLE_IN,
	input  wire logic       CONDITION_IN,
	input  wire logic [1:0] SELECT_IN,
	output logic            IRQ_OUT
);
	import ptsr_pkg::*;

	logic [STRETCH_WIDTH-1:0] count;
	logic                     held;
	logic [STRETCH_WIDTH-1:0] load;

	// Chooses the reload value from the stretch select.
	always_comb begin
		case (SELECT_IN)
			STRETCH_SHORT: load = STRETCH_WIDTH'(SHORT_CYC); // R17
			STRETCH_MID:   load = STRETCH_WIDTH'(MID_CYC);
			STRETCH_LONG:  load = STRETCH_WIDTH'(LONG_CYC);
			default:       load = '0;
		endcase
	end

	// Reloads on a fresh condition, otherwise counts down to zero.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			count <= '0;
		end else if (ENABLE_IN) begin
			if (SAMPLE_IN && CONDITION_IN) begin
				count <= load; // R17
			end else if (count != '0) begin
				count <= count - 1'b1;
			end
		end
	end

	// Holds the condition from the most recent evaluated sample.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			held <= 1'b0;
		end else if (ENABLE_IN && SAMPLE_IN) begin
			held <= CONDITION_IN; // R18
		end
	end

	// Without stretch the output follows the held condition.
	assign IRQ_OUT = (SELECT_IN == STRETCH_NONE) ? held : (count != '0); // R18

endmodule // ptsr_stretch

/* core/ptsr_regs.sv */
// Pressure threshold, user offset and status register slice.
`timescale 1ns/10ps

// Behaviour
// R01: Limits and offset writable only before init lock.
// R02: Limits and offset feed register array error check.
// R03: Two unsigned 16-bit limits drive window comparator.
// R04: Zero limit disables only that comparison.
// R05: Both limits zero keeps interrupt off.
// R06: Signed offset added to calibrated pressure.
// R07: Offset change resets signal-processing path.
// R08: Host waits for path init after offset change.
// R09: Host picks offset avoiding saturation or compression.
// R10: Not-run flag set by reset, cleared by selection.
// R11: Running flag is OR of selection bits.
// R12: Common-mode fault sets, clears on read or report.
// R13: Self-test fault clears only on reset.
// R14: Mirror returns device status, bit six zero.
// R15: Mirror read has primary status read effects.
// R16: Sense bit picks inside or outside window.
// R17: Stretch select reloads counter of chosen length.
// R18: No stretch: output follows latest sample condition.
// R19: Compare adjusted result; above high or below low.
// R20: Status writes ignored, reserved bits read zero.
module ptsr_regs #(
	parameter int SHORT_CYC = ptsr_pkg::STRETCH_SHORT_CYC,
	parameter int MID_CYC   = ptsr_pkg::STRETCH_MID_CYC,
	parameter int LONG_CYC  = ptsr_pkg::STRETCH_LONG_CYC
) (
	input  wire logic        CLK_IN,
	input  wire logic        RESET_IN,
	input  wire logic        ENABLE_IN,
	input  wire logic [7:0]  ADDR_IN,
	input  wire logic        WRITE_IN,
	input  wire logic        READ_IN,
	input  wire logic [7:0]  WDATA_IN,
	input  wire logic        INIT_LOCK_BIT_IN,
	input  wire logic [15:0] CALIBRATED_IN,
	input  wire logic        SAMPLE_VALID_IN,
	input  wire logic        WINDOW_SENSE_IN,
	input  wire logic [1:0]  STRETCH_SELECT_IN,
	input  wire logic [3:0]  SELFTEST_SELECT_IN,
	input  wire logic        SELFTEST_SELECT_WRITE_IN,
	input  wire logic        COMMON_MODE_OUT_OF_LIMIT_IN,
	input  wire logic        COMMON_MODE_REPORTED_IN,
	input  wire logic        SELFTEST_FAILED_IN,
	input  wire logic [7:0]  DEVICE_STATUS_IN,
	output logic      [7:0]  RDATA_OUT,
	output logic             DEVICE_STATUS_READ_OUT,
	output logic [15:0]      ADJUSTED_OUT,
	output logic             PATH_RESET_OUT,
	output logic             INTERRUPT_OUT,
	output logic [47:0]      ARRAY_CHECK_OUT
);
	import ptsr_pkg::*;

	logic [7:0]  limit_high_lo;
	logic [7:0]  limit_high_hi;
	logic [7:0]  limit_low_lo;
	logic [7:0]  limit_low_hi;
	logic [7:0]  offset_lo;
	logic [7:0]  offset_hi;
	logic        change_offset_lo;
	logic        change_offset_hi;
	logic [15:0] pressure_limit_high;
	logic [15:0] pressure_limit_low;
	logic [15:0] user_offset;
	logic        selftest_not_run;
	logic        common_mode_fault;
	logic        selftest_fault;
	logic        selftest_running;
	logic        status_read;
	logic        mirror_read;
	logic        above_high;
	logic        below_low;
	logic        outside;
	logic        condition;
	logic [7:0]  next_rdata;
	logic [7:0]  signal_status;
	logic        wr_high_lo;
	logic        wr_high_hi;
	logic        wr_low_lo;
	logic        wr_low_hi;
	logic        wr_offset_lo;
	logic        wr_offset_hi;

	// Address decode of writes; status addresses take no write.
	assign wr_high_lo   = WRITE_IN && (ADDR_IN == ADDR_LIMIT_HIGH_LO);
	assign wr_high_hi   = WRITE_IN && (ADDR_IN == ADDR_LIMIT_HIGH_HI);
	assign wr_low_lo    = WRITE_IN && (ADDR_IN == ADDR_LIMIT_LOW_LO);
	assign wr_low_hi    = WRITE_IN && (ADDR_IN == ADDR_LIMIT_LOW_HI);
	assign wr_offset_lo = WRITE_IN && (ADDR_IN == ADDR_OFFSET_LO);
	assign wr_offset_hi = WRITE_IN && (ADDR_IN == ADDR_OFFSET_HI); // R20

	// Each byte is its own register and a word is never latched as a pair, so the
	// comparator sees a half-written limit between the two byte writes.
	// Lockable limit and offset bytes.
	ptsr_lock_reg u_high_lo (
		.CLK_IN     (CLK_IN),
		.RESET_IN   (RESET_IN),
		.ENABLE_IN  (ENABLE_IN),
		.WRITE_IN   (wr_high_lo),
		.LOCK_IN    (INIT_LOCK_BIT_IN),
		.DATA_IN    (WDATA_IN),
		.VALUE_OUT  (limit_high_lo),
		.CHANGE_OUT ()
	);
	ptsr_lock_reg u_high_hi (
		.CLK_IN     (CLK_IN),
		.RESET_IN   (RESET_IN),
		.ENABLE_IN  (ENABLE_IN),
		.WRITE_IN   (wr_high_hi),
		.LOCK_IN    (INIT_LOCK_BIT_IN),
		.DATA_IN    (WDATA_IN),
		.VALUE_OUT  (limit_high_hi),
		.CHANGE_OUT ()
	);
	ptsr_lock_reg u_low_lo (
		.CLK_IN     (CLK_IN),
		.RESET_IN   (RESET_IN),
		.ENABLE_IN  (ENABLE_IN),
		.WRITE_IN   (wr_low_lo),
		.LOCK_IN    (INIT_LOCK_BIT_IN),
		.DATA_IN    (WDATA_IN),
		.VALUE_OUT  (limit_low_lo),
		.CHANGE_OUT ()
	);
	ptsr_lock_reg u_low_hi (
		.CLK_IN     (CLK_IN),
		.RESET_IN   (RESET_IN),
		.ENABLE_IN  (ENABLE_IN),
		.WRITE_IN   (wr_low_hi),
		.LOCK_IN    (INIT_LOCK_BIT_IN),
		.DATA_IN    (WDATA_IN),
		.VALUE_OUT  (limit_low_hi),
		.CHANGE_OUT ()
	);
	ptsr_lock_reg u_offset_lo (
		.CLK_IN     (CLK_IN),
		.RESET_IN   (RESET_IN),
		.ENABLE_IN  (ENABLE_IN),
		.WRITE_IN   (wr_offset_lo),
		.LOCK_IN    (INIT_LOCK_BIT_IN),
		.DATA_IN    (WDATA_IN),
		.VALUE_OUT  (offset_lo),
		.CHANGE_OUT (change_offset_lo)
	);
	ptsr_lock_reg u_offset_hi (
		.CLK_IN     (CLK_IN),
		.RESET_IN   (RESET_IN),
		.ENABLE_IN  (ENABLE_IN),
		.WRITE_IN   (wr_offset_hi),
		.LOCK_IN    (INIT_LOCK_BIT_IN),
		.DATA_IN    (WDATA_IN),
		.VALUE_OUT  (offset_hi),
		.CHANGE_OUT (change_offset_hi)
	);

	assign pressure_limit_high = {limit_high_hi, limit_high_lo};
	assign pressure_limit_low  = {limit_low_hi, limit_low_lo};
	assign user_offset         = {offset_hi, offset_lo};

	// Exposes the limit and offset words to the array error checker.
	assign ARRAY_CHECK_OUT = {user_offset, pressure_limit_low, pressure_limit_high}; // R02

	// Only an accepted write whose data differs restarts the path, so a host that
	// rewrites the same offset does not throw away valid results.
	// Pulse that restarts the signal path when the offset changes.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			PATH_RESET_OUT <= 1'b0;
		end else if (ENABLE_IN) begin
			PATH_RESET_OUT <= change_offset_lo || change_offset_hi; // R07
		end
	end

	// Signed offset added modulo 16 bits to the calibrated result.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			ADJUSTED_OUT <= RESET_WORD;
		end else if (ENABLE_IN) begin
			ADJUSTED_OUT <= CALIBRATED_IN + user_offset; // R06
		end
	end

	// The adjusted word wraps modulo 16 bits, so a badly chosen offset can push a
	// low pressure past the high limit; keeping clear of that is up to the host.
	// Window comparison on the adjusted result, unsigned limits.
	assign above_high = (pressure_limit_high != RESET_WORD)
		&& (ADJUSTED_OUT > pressure_limit_high); // R04 R19
	assign below_low  = (pressure_limit_low != RESET_WORD)
		&& (ADJUSTED_OUT < pressure_limit_low); // R04 R19
	assign outside    = above_high || below_low; // R03

	// Sense bit chooses outside or inside; both zero limits disable it.
	always_comb begin
		if ((pressure_limit_high == RESET_WORD) && (pressure_limit_low == RESET_WORD)) begin
			condition = 1'b0; // R05
		end else if (WINDOW_SENSE_IN) begin
			condition = !outside; // R16
		end else begin
			condition = outside; // R16
		end
	end

	// Interrupt stretch and hold logic.
	ptsr_stretch #(
		.SHORT_CYC (SHORT_CYC),
		.MID_CYC   (MID_CYC),
		.LONG_CYC  (LONG_CYC)
	) u_stretch (
		.CLK_IN       (CLK_IN),
		.RESET_IN     (RESET_IN),
		.ENABLE_IN    (ENABLE_IN),
		.SAMPLE_IN    (SAMPLE_VALID_IN),
		.CONDITION_IN (condition),
		.SELECT_IN    (STRETCH_SELECT_IN),
		.IRQ_OUT      (INTERRUPT_OUT)
	);

	// Read strobes for the status registers.
	assign status_read = ENABLE_IN && READ_IN && (ADDR_IN == ADDR_SIGNAL_STATUS);
	assign mirror_read = ENABLE_IN && READ_IN && (ADDR_IN == ADDR_STATUS_MIRROR);
	assign DEVICE_STATUS_READ_OUT = mirror_read; // R15

	// Self-test not-run flag: set by reset, cleared by nonzero selection.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			selftest_not_run <= 1'b1;
		end else if (ENABLE_IN && SELFTEST_SELECT_WRITE_IN && (SELFTEST_SELECT_IN != 4'h0)) begin
			selftest_not_run <= 1'b0; // R10
		end
	end

	assign selftest_running = |SELFTEST_SELECT_IN; // R11

	// Common-mode fault; a fresh event wins over a clear.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			common_mode_fault <= 1'b0;
		end else if (ENABLE_IN) begin
			if (COMMON_MODE_OUT_OF_LIMIT_IN) begin
				common_mode_fault <= 1'b1; // R12
			end else if (status_read || COMMON_MODE_REPORTED_IN) begin
				common_mode_fault <= 1'b0; // R12
			end
		end
	end

	// No read clears this flag, so a failed self-test stays visible to every poll.
	// Self-test fault is sticky until device reset.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			selftest_fault <= 1'b0;
		end else if (ENABLE_IN && SELFTEST_FAILED_IN) begin
			selftest_fault <= 1'b1; // R13
		end
	end

	// Assembled signal-path status byte, upper bits reserved as zero.
	always_comb begin
		signal_status = RESET_BYTE;
		signal_status[BIT_SELFTEST_NOT_RUN]  = selftest_not_run;
		signal_status[BIT_SELFTEST_RUNNING]  = selftest_running;
		signal_status[BIT_COMMON_MODE_FAULT] = common_mode_fault;
		signal_status[BIT_SELFTEST_FAULT]    = selftest_fault; // R20
	end

	// Read data multiplexer.
	always_comb begin
		next_rdata = RESET_BYTE;
		if (ADDR_IN == ADDR_LIMIT_HIGH_LO) begin
			next_rdata = limit_high_lo;
		end else if (ADDR_IN == ADDR_LIMIT_HIGH_HI) begin
			next_rdata = limit_high_hi;
		end else if (ADDR_IN == ADDR_LIMIT_LOW_LO) begin
			next_rdata = limit_low_lo;
		end else if (ADDR_IN == ADDR_LIMIT_LOW_HI) begin
			next_rdata = limit_low_hi;
		end else if (ADDR_IN == ADDR_OFFSET_LO) begin
			next_rdata = offset_lo;
		end else if (ADDR_IN == ADDR_OFFSET_HI) begin
			next_rdata = offset_hi;
		end else if (ADDR_IN == ADDR_SIGNAL_STATUS) begin
			next_rdata = signal_status;
		end else if (ADDR_IN == ADDR_STATUS_MIRROR) begin
			next_rdata = DEVICE_STATUS_IN; // R14
			next_rdata[BIT_STATUS_RESERVED] = 1'b0; // R14
		end
	end

	// A status read returns the flags as they stood before its own clear, so a
	// fault that was set once is lost before the next read only if the report input clears it.
	// Read data is registered one cycle after the read strobe.
	always_ff @(posedge CLK_IN or posedge RESET_IN) begin
		if (RESET_IN) begin
			RDATA_OUT <= RESET_BYTE;
		end else if (ENABLE_IN && READ_IN) begin
			RDATA_OUT <= next_rdata;
		end
	end

endmodule // ptsr_regs

/* tb/ptsr_regs_properties.sv */
// Concurrent checks on the ports of the register slice.
`timescale 1ns/10ps

module ptsr_regs_properties
	import ptsr_pkg::*;
(
	input wire logic        CLK_IN,
	input wire logic        RESET_IN,
	input wire logic        ENABLE_IN,
	input wire logic [7:0]  ADDR_IN,
	input wire logic        WRITE_IN,
	input wire logic        READ_IN,
	input wire logic        INIT_LOCK_BIT_IN,
	input wire logic [15:0] CALIBRATED_IN,
	input wire logic        SAMPLE_VALID_IN,
	input wire logic [1:0]  STRETCH_SELECT_IN,
	input wire logic [3:0]  SELFTEST_SELECT_IN,
	input wire logic [7:0]  DEVICE_STATUS_IN,
	input wire logic [7:0]  RDATA_OUT,
	input wire logic        DEVICE_STATUS_READ_OUT,
	input wire logic [15:0] ADJUSTED_OUT,
	input wire logic        PATH_RESET_OUT,
	input wire logic        INTERRUPT_OUT,
	input wire logic [47:0] ARRAY_CHECK_OUT
);
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RESET_IN);

	// Accesses and idle spans that the properties start from.
	sequence status_read;
		READ_IN && ENABLE_IN && ADDR_IN == ADDR_SIGNAL_STATUS;
	endsequence
	sequence mirror_read;
		READ_IN && ENABLE_IN && ADDR_IN == ADDR_STATUS_MIRROR;
	endsequence
	sequence idle_plain;
		STRETCH_SELECT_IN == STRETCH_NONE && !SAMPLE_VALID_IN;
	endsequence

	// Read side effects and read data of the two status places.
	chk_mirror_read_pulse: assert property (
		DEVICE_STATUS_READ_OUT == (READ_IN && ENABLE_IN && ADDR_IN == ADDR_STATUS_MIRROR))
		else $error("status read pulse mismatch");
	chk_mirror_copy_value: assert property (
		mirror_read |=> RDATA_OUT == ($past(DEVICE_STATUS_IN) & 8'hBF))
		else $error("mirror read data mismatch");
	chk_running_flag_or: assert property (
		status_read |=> RDATA_OUT[2] == $past(|SELFTEST_SELECT_IN) && RDATA_OUT[7:4] == 4'h0)
		else $error("status running or reserved bits wrong");

	// Lock, path reset and stored words.
	chk_locked_no_reset: assert property (
		WRITE_IN && ENABLE_IN && INIT_LOCK_BIT_IN |=> !PATH_RESET_OUT)
		else $error("path reset after locked write");
	chk_path_reset_cause: assert property (
		PATH_RESET_OUT |-> $past(WRITE_IN && ENABLE_IN && !INIT_LOCK_BIT_IN && ADDR_IN[7:1] == 7'h26))
		else $error("path reset without open offset write");
	chk_array_words_hold: assert property (
		!(WRITE_IN && ENABLE_IN && !INIT_LOCK_BIT_IN) |=> $stable(ARRAY_CHECK_OUT))
		else $error("stored words changed without open write");
	chk_adjusted_sum_value: assert property (
		!$past(RESET_IN) && $past(ENABLE_IN) |->
		ADJUSTED_OUT == $past(CALIBRATED_IN) + $past(ARRAY_CHECK_OUT[47:32]))
		else $error("adjusted result mismatch");

	// Interrupt output without stretch.
	chk_both_zero_off: assert property (
		SAMPLE_VALID_IN && ENABLE_IN && STRETCH_SELECT_IN == STRETCH_NONE &&
		ARRAY_CHECK_OUT[31:0] == 32'h0000_0000 |=> !INTERRUPT_OUT)
		else $error("interrupt with both limits zero");
	chk_idle_irq_holds: assert property (
		idle_plain [*2] |=> $stable(INTERRUPT_OUT))
		else $error("interrupt moved between samples");
endmodule // ptsr_regs_properties

/* tb/ptsr_host_model.sv */
// Host processor model that issues register reads and writes.
`timescale 1ns/10ps

module ptsr_host_model (
	input  wire logic       clk_in,
	input  wire logic [7:0] rdata_in,
	output logic      [7:0] addr_out,
	output logic            write_out,
	output logic            read_out,
	output logic      [7:0] wdata_out
);
	// Idle bus at time zero.
	initial begin
		addr_out  = 8'h00;
		write_out = 1'b0;
		read_out  = 1'b0;
		wdata_out = 8'h00;
	end

	// One write; address and data flip once taken so stale values never look valid.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out  <= a;
		wdata_out <= d;
		write_out <= 1'b1;
		@(posedge clk_in);
		write_out <= 1'b0;
		addr_out  <= ~a;
		wdata_out <= ~d;
	endtask

	// One read of this slice only, never of sensor results after an offset change.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		read_out <= 1'b1;
		@(posedge clk_in);
		read_out <= 1'b0;
		addr_out <= ~a;
		#1;
		d = rdata_in;
	endtask
endmodule // ptsr_host_model

/* tb/ptsr_regs_bench.sv */
// Self-checking bench of the pressure threshold and status register slice.
`timescale 1ns/10ps

module ptsr_regs_bench;
	import ptsr_pkg::*;
	localparam int SHORT = 4;
	localparam int MID   = 8;
	localparam int LONG  = 16;
	logic        clk;
	logic        rst   = 1'b1;
	logic        lock  = 1'b0;
	logic        sv    = 1'b0;
	logic        sense = 1'b0;
	logic        selw  = 1'b0;
	logic        cm    = 1'b0;
	logic        cmr   = 1'b0;
	logic        stf   = 1'b0;
	logic        en    = 1'b1;
	logic [15:0] cal   = 16'h0000;
	logic [1:0]  str   = STRETCH_NONE;
	logic [3:0]  sel   = 4'h0;
	logic [7:0]  dst   = 8'h00;
	logic [7:0]  addr;
	logic [7:0]  wd;
	logic        wr;
	logic        rd;
	logic [7:0]  rdata;
	logic [15:0] adj;
	logic        irq;
	logic        prst;
	logic        dsr;
	logic [47:0] arr;
	logic [15:0] n;
	logic [7:0]  places [7] = '{8'h46, 8'h47, 8'h48, 8'h49, 8'h4C, 8'h4D, 8'h50};
	logic [15:0] lens [4]   = '{16'h0000, 16'(SHORT), 16'(MID), 16'(LONG)};
	int          num_errors = 0;
	int          checks     = 0;
	int          path_resets  = 0;
	int          status_reads = 0;

	// Host side and the slice under test.
	ptsr_host_model host_u (
		.clk_in    (clk),
		.rdata_in  (rdata),
		.addr_out  (addr),
		.write_out (wr),
		.read_out  (rd),
		.wdata_out (wd)
	);
	ptsr_regs #(.SHORT_CYC(SHORT), .MID_CYC(MID), .LONG_CYC(LONG)) dut_u (
		.CLK_IN                      (clk),
		.RESET_IN                    (rst),
		.ENABLE_IN                   (en),
		.ADDR_IN                     (addr),
		.WRITE_IN                    (wr),
		.READ_IN                     (rd),
		.WDATA_IN                    (wd),
		.INIT_LOCK_BIT_IN            (lock),
		.CALIBRATED_IN               (cal),
		.SAMPLE_VALID_IN             (sv),
		.WINDOW_SENSE_IN             (sense),
		.STRETCH_SELECT_IN           (str),
		.SELFTEST_SELECT_IN          (sel),
		.SELFTEST_SELECT_WRITE_IN    (selw),
		.COMMON_MODE_OUT_OF_LIMIT_IN (cm),
		.COMMON_MODE_REPORTED_IN     (cmr),
		.SELFTEST_FAILED_IN          (stf),
		.DEVICE_STATUS_IN            (dst),
		.RDATA_OUT                   (rdata),
		.DEVICE_STATUS_READ_OUT      (dsr),
		.ADJUSTED_OUT                (adj),
		.PATH_RESET_OUT              (prst),
		.INTERRUPT_OUT               (irq),
		.ARRAY_CHECK_OUT             (arr)
	);

	// Clock of 40 ns period.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Counts path restart pulses and device status read pulses from mirror reads as each edge samples them.
	always @(posedge clk) begin
		if (prst) begin
			path_resets <= path_resets + 1;
		end
		if (dsr) begin
			status_reads <= status_reads + 1;
		end
	end

	// Compares one value and counts it.
	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Reads one register and compares the byte.
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host_u.rd(a, v);
		check("rdata", {8'h00, exp}, {8'h00, v});
	endtask

	// Applies a pressure, evaluates one sample and compares the interrupt.
	task automatic smp(input logic [15:0] c, input logic s, input logic exp);
		@(posedge clk);
		cal   <= c;
		sense <= s;
		repeat (2) @(posedge clk);
		sv <= 1'b1;
		@(posedge clk);
		sv <= 1'b0;
		@(posedge clk);
		#1;
		check("interrupt", {15'h0000, exp}, {15'h0000, irq});
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Cuts a hang short; the tests need well under a thousand cycles.
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		stop_test();
	end

	// Test sequence.
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		foreach (places[i]) begin
			rchk(places[i], 8'h00);
		end
		rchk(ADDR_SIGNAL_STATUS, 8'h08);
		$display("test reset values done");
		host_u.wr(ADDR_LIMIT_HIGH_LO, 8'h34);
		host_u.wr(ADDR_LIMIT_HIGH_HI, 8'h12);
		host_u.wr(ADDR_LIMIT_LOW_HI, 8'h10);
		rchk(ADDR_LIMIT_HIGH_HI, 8'h12);
		// An offset of minus sixteen keeps results clear of the upper rail; the 0010 sample lands on zero.
		host_u.wr(ADDR_OFFSET_LO, 8'hF0);
		host_u.wr(ADDR_OFFSET_HI, 8'hFF);
		smp(16'h2000, 1'b0, 1'b1);
		check("adjusted", 16'h1FF0, adj);
		smp(16'h2000, 1'b1, 1'b0);
		smp(16'h1100, 1'b1, 1'b1);
		smp(16'h1244, 1'b0, 1'b0);
		smp(16'h0F00, 1'b0, 1'b1);
		host_u.wr(ADDR_LIMIT_LOW_HI, 8'h00);
		smp(16'h0010, 1'b0, 1'b0);
		smp(16'h2000, 1'b0, 1'b1);
		host_u.wr(ADDR_LIMIT_HIGH_HI, 8'h00);
		host_u.wr(ADDR_LIMIT_HIGH_LO, 8'h00);
		smp(16'h2000, 1'b0, 1'b0);
		smp(16'h2000, 1'b1, 1'b0);
		$display("test window done");
		host_u.wr(ADDR_LIMIT_HIGH_HI, 8'h12);
		for (int s = 1; s < 4; s++) begin
			@(posedge clk);
			str   <= s[1:0];
			sense <= 1'b0;
			sv  <= 1'b1;
			@(posedge clk);
			sv <= 1'b0;
			n = 16'h0000;
			repeat (24) begin
				#1;
				n = n + {15'h0000, irq};
				@(posedge clk);
			end
			check("stretch", lens[s], n);
		end
		str <= STRETCH_NONE;
		$display("test stretch done");
		@(posedge clk);
		sel  <= 4'h1;
		selw <= 1'b1;
		@(posedge clk);
		selw <= 1'b0;
		rchk(ADDR_SIGNAL_STATUS, 8'h04);
		@(posedge clk);
		sel  <= 4'h0;
		selw <= 1'b1;
		@(posedge clk);
		selw <= 1'b0;
		rchk(ADDR_SIGNAL_STATUS, 8'h00);
		@(posedge clk);
		cm <= 1'b1;
		@(posedge clk);
		cm <= 1'b0;
		rchk(ADDR_SIGNAL_STATUS, 8'h02);
		rchk(ADDR_SIGNAL_STATUS, 8'h00);
		@(posedge clk);
		cm <= 1'b1;
		@(posedge clk);
		cm  <= 1'b0;
		cmr <= 1'b1;
		@(posedge clk);
		cmr <= 1'b0;
		rchk(ADDR_SIGNAL_STATUS, 8'h00);
		@(posedge clk);
		stf <= 1'b1;
		@(posedge clk);
		stf <= 1'b0;
		rchk(ADDR_SIGNAL_STATUS, 8'h01);
		rchk(ADDR_SIGNAL_STATUS, 8'h01);
		@(posedge clk);
		dst <= 8'hFF;
		host_u.wr(ADDR_SIGNAL_STATUS, 8'hFF);
		host_u.wr(ADDR_STATUS_MIRROR, 8'h00);
		rchk(ADDR_SIGNAL_STATUS, 8'h01);
		rchk(ADDR_STATUS_MIRROR, 8'hBF);
		$display("test status done");
		// A write while the clock enable is low must leave the byte untouched.
		@(posedge clk);
		en <= 1'b0;
		host_u.wr(ADDR_LIMIT_HIGH_LO, 8'h55);
		en <= 1'b1;
		rchk(ADDR_LIMIT_HIGH_LO, 8'h00);
		$display("test enable done");
		@(posedge clk);
		lock <= 1'b1;
		host_u.wr(ADDR_LIMIT_HIGH_HI, 8'hAA);
		host_u.wr(ADDR_OFFSET_HI, 8'h00);
		rchk(ADDR_LIMIT_HIGH_HI, 8'h12);
		rchk(ADDR_OFFSET_HI, 8'hFF);
		check("path resets", 16'h0002, 16'(path_resets));
		check("status reads", 16'h0001, 16'(status_reads));
		check("offset word", 16'hFFF0, arr[47:32]);
		check("low limit word", 16'h0000, arr[31:16]);
		check("high limit word", 16'h1200, arr[15:0]);
		$display("test lock done");
		stop_test();
	end
endmodule // ptsr_regs_bench

bind ptsr_regs ptsr_regs_properties chk_u (.*);
